// ===== verilog/tcc_pkg.sv
// constants and types shared by the tape controller channel command interface
package tcc_pkg;

	// ----------------------------------------
	// geometry of the register memory
	// ----------------------------------------
	localparam int NUM_CH        = 4;
	localparam int REGS_PER_CH   = 32;
	localparam int WORD_W        = 16;
	localparam int MEM_WORDS     = NUM_CH * REGS_PER_CH;
	localparam int MEM_AW        = 7;
	localparam int ID_W          = 7;

	// ----------------------------------------
	// function codes
	// ----------------------------------------
	localparam logic [5:0] FC_CTRL_W  = 6'h01;
	localparam logic [5:0] FC_INTC_W  = 6'h03;
	localparam logic [5:0] FC_TASK_W  = 6'h07;
	localparam logic [5:0] FC_ADDR_W  = 6'h09;
	localparam logic [5:0] FC_RANGE_W = 6'h0d;
	localparam logic [5:0] FC_STAT1_R = 6'h18;

	// ----------------------------------------
	// field positions, counts and reset values
	// ----------------------------------------
	localparam int          CTL_INIT_BIT = 0;
	localparam int          RETRY_CYC    = 16;
	localparam logic [7:0]  RETRY_LOAD   = 8'(RETRY_CYC);
	localparam logic [3:0]  CH_RST       = 4'h0;
	localparam logic [7:0]  CNT_RST      = 8'h00;
	localparam logic [15:0] WORD_RST     = 16'h0000;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic [6:0]  ctl_id;
		logic [1:0]  port;
		logic        dir;
		logic [5:0]  fc;
		logic [15:0] data;
	} tcc_cmd_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_RANGE = 3'b010,
		ST_RSP   = 3'b100
	} tcc_state_t;

	typedef struct packed {
		tcc_state_t  st;
		logic [15:0] pend_data;
		logic [1:0]  pend_port;
		logic [3:0]  op_pend;
		logic        xfer_act;
		logic [1:0]  act_port;
		logic        xfer_start;
		logic [3:0]  dir;
		logic [3:0]  lvl_nz;
		logic [3:0]  int_pend;
		logic [3:0]  attn;
		logic [3:0]  done;
		logic [7:0]  retry_cnt;
	} tcc_regs_t;

endpackage

// ===== verilog/tcc_regmem.sv
// per-channel register memory, one port, registered read data
`timescale 1ns/1ps
module tcc_regmem
	import tcc_pkg::*;
#(
	parameter int WORDS = MEM_WORDS,
	parameter int AW    = MEM_AW,
	parameter int DW    = WORD_W
) (
	// clock
	input  wire logic          core_clk,
	// access
	input  wire logic          we,
	input  wire logic          re,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata
);

	logic [DW-1:0] mem [WORDS];

	always_ff @(posedge core_clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		if (re) begin
			rdata <= mem[addr];
		end
	end

endmodule

// ===== verilog/tcc_cmd_iface.sv
// tape controller channel command interface: registers, scheduling, interrupts
//
// Notes on behaviour
// [R1] 128 words, 32 per channel, 16 bits
// [R2] register address is port bits plus fc[5:1]
// [R3] register access accepted while channel idle
// [R4] write in one transfer, read answered later
// [R5] task word write starts the operation
// [R6] decode id 8-14, port 15-16, direction 17
// [R7] both direction values reach the same unit
// [R8] direction latched only by transfer setup load
// [R9] one transfer active, others wait queued
// [R10] interrupt on completion or attention, level nonzero
// [R11] refused interrupt held and retried later
// [R12] pending interrupt keeps channel busy, control allowed
// [R13] zero level: no interrupt, status still set
// [R14] zero level plus init or clear discards
// [R15] transfer setup load also loads range
// [R16] refused command answered negatively, registers untouched
`timescale 1ns/1ps
module tcc_cmd_iface
	import tcc_pkg::*;
(
	// clock and reset
	input  wire logic          core_clk,
	input  wire logic          sys_rst,
	// configuration
	input  wire logic [6:0]    ctl_id_sw,
	input  wire logic          mclr,
	// command from the central processor
	input  wire logic          cmd_valid,
	input  wire tcc_cmd_t      cmd,
	output logic               cmd_ready,
	output logic               cmd_ack,
	output logic               cmd_nak,
	// second transfer carrying read data
	output logic               rsp_valid,
	output logic [15:0]        rsp_data,
	// tape side transfer scheduling
	output logic               xfer_start,
	output logic [1:0]         xfer_port,
	output logic               xfer_dir,
	input  wire logic          xfer_done,
	input  wire logic [3:0]    attn_in,
	// interrupt cycle
	output logic               irq_req,
	output logic [1:0]         irq_port,
	input  wire logic          irq_ack,
	input  wire logic          irq_nak,
	// status flags
	output logic [3:0]         stat_done,
	output logic [3:0]         stat_attn,
	output logic [3:0]         ch_busy
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [1:0] first_set(input logic [3:0] v);
		first_set = 2'd0;
		for (int i = 3; i >= 0; i--) begin
			if (v[i]) begin
				first_set = 2'(i);
			end
		end
	endfunction

	function automatic logic [3:0] dec_port(input logic [1:0] p);
		dec_port = 4'h1 << p;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	tcc_regs_t s_r;
	tcc_regs_t s_nxt;

	logic              hit;
	logic              refuse;
	logic              take;
	logic              is_ctrl;
	logic              is_write;
	logic [3:0]        p_oh;
	logic [3:0]        act_oh;
	logic              mem_we;
	logic              mem_re;
	logic [MEM_AW-1:0] mem_addr;
	logic [15:0]       mem_wdata;

	// busy covers queued, running and interrupt-pending channels
	always_comb begin
		act_oh  = s_r.xfer_act ? dec_port(s_r.act_port) : CH_RST;
		ch_busy = s_r.op_pend | act_oh | s_r.int_pend; // R12
	end

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	always_comb begin
		p_oh      = dec_port(cmd.port);                          // R6 R7
		is_ctrl   = (cmd.fc == FC_CTRL_W);
		is_write  = cmd.fc[0];
		hit       = cmd_valid && (s_r.st == ST_IDLE) && (cmd.ctl_id == ctl_id_sw); // R6
		refuse    = hit && ((ch_busy & p_oh) != CH_RST) && !is_ctrl; // R3 R12 R16
		take      = hit && !refuse;
		cmd_ready = (s_r.st == ST_IDLE);
		cmd_ack   = take;
		cmd_nak   = refuse;                                      // R16
		mem_we    = (take && is_write) || (s_r.st == ST_RANGE);  // R4 R15
		mem_re    = take && !is_write;
		mem_addr  = (s_r.st == ST_RANGE) ? {s_r.pend_port, FC_RANGE_W[5:1]}
		                                 : {cmd.port, cmd.fc[5:1]}; // R2
		mem_wdata = (s_r.st == ST_RANGE) ? s_r.pend_data : cmd.data;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_nxt            = s_r;
		s_nxt.xfer_start = 1'b0;
		if (s_r.retry_cnt != CNT_RST) begin
			s_nxt.retry_cnt = s_r.retry_cnt - 8'h01;             // R11
		end

		unique case (s_r.st)
			ST_IDLE: begin
				if (take) begin
					if (!is_write) begin
						s_nxt.st = ST_RSP;                       // R4
						if (cmd.fc == FC_STAT1_R) begin
							s_nxt.attn = s_r.attn & ~p_oh;
						end
					end
					if (cmd.fc == FC_ADDR_W) begin
						s_nxt.dir[cmd.port] = cmd.dir;           // R8
						s_nxt.pend_data     = cmd.data;
						s_nxt.pend_port     = cmd.port;
						s_nxt.st            = ST_RANGE;          // R15
					end
					if (cmd.fc == FC_INTC_W) begin
						s_nxt.lvl_nz[cmd.port] = (cmd.data != WORD_RST); // R13
					end
					if (cmd.fc == FC_TASK_W) begin
						s_nxt.op_pend[cmd.port] = 1'b1;          // R5
						s_nxt.done[cmd.port]    = 1'b0;
					end
					if (is_ctrl && cmd.data[CTL_INIT_BIT] && !s_r.lvl_nz[cmd.port]) begin
						s_nxt.int_pend[cmd.port] = 1'b0;         // R14
					end
				end
			end
			ST_RANGE: s_nxt.st = ST_IDLE;
			ST_RSP:   s_nxt.st = ST_IDLE;
			default:  s_nxt.st = ST_IDLE;
		endcase

		// clears first so that a coinciding event wins
		if (mclr) begin
			s_nxt.int_pend = s_nxt.int_pend & s_r.lvl_nz;       // R14
			s_nxt.op_pend  = CH_RST;
		end
		if (irq_req && irq_ack) begin
			s_nxt.int_pend[irq_port] = 1'b0;
		end
		if (irq_req && irq_nak) begin
			s_nxt.retry_cnt = RETRY_LOAD;                        // R11
		end

		// single transfer in flight, queued ones start in port order
		if (s_r.xfer_act && xfer_done) begin
			s_nxt.xfer_act = 1'b0;                               // R9
			s_nxt.done[s_r.act_port] = 1'b1;                     // R13
			if (s_r.lvl_nz[s_r.act_port]) begin
				s_nxt.int_pend[s_r.act_port] = 1'b1;             // R10
			end
		end else if (!s_r.xfer_act && (s_r.op_pend != CH_RST) && !mclr) begin
			s_nxt.xfer_act   = 1'b1;                             // R9
			s_nxt.act_port   = first_set(s_r.op_pend);
			s_nxt.xfer_start = 1'b1;
			s_nxt.op_pend[first_set(s_r.op_pend)] = 1'b0;
		end

		// control word without the init bit completes at once
		if (take && is_ctrl && !cmd.data[CTL_INIT_BIT]) begin
			s_nxt.done[cmd.port] = 1'b1;
			if (s_r.lvl_nz[cmd.port]) begin
				s_nxt.int_pend[cmd.port] = 1'b1;                 // R10
			end
		end

		s_nxt.attn     = s_nxt.attn | attn_in;                   // R13
		s_nxt.int_pend = s_nxt.int_pend | (attn_in & s_r.lvl_nz); // R10
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '{st: ST_IDLE, pend_data: WORD_RST, retry_cnt: CNT_RST, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_comb begin
		irq_port   = first_set(s_r.int_pend & s_r.lvl_nz);
		irq_req    = ((s_r.int_pend & s_r.lvl_nz) != CH_RST)
		             && (s_r.retry_cnt == CNT_RST);              // R11 R13
		rsp_valid  = (s_r.st == ST_RSP);                         // R4
		xfer_start = s_r.xfer_start;
		xfer_port  = s_r.act_port;
		xfer_dir   = s_r.dir[s_r.act_port];
		stat_done  = s_r.done;
		stat_attn  = s_r.attn;
	end

	tcc_regmem tcc_regmem_inst (
		.core_clk (core_clk),
		.we       (mem_we),
		.re       (mem_re),
		.addr     (mem_addr),
		.wdata    (mem_wdata),
		.rdata    (rsp_data)
	); // R1

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence seq_read_cmd;
		take && !is_write;
	endsequence

	sequence seq_setup_cmd;
		take && (cmd.fc == FC_ADDR_W);
	endsequence

	a_refuse_busy: assert property (@(posedge core_clk) disable iff (sys_rst) // R12
		hit && ((s_r.int_pend & p_oh) != CH_RST) && !is_ctrl |-> cmd_nak && !mem_we)
		else $error("busy channel command not refused");

	a_read_answer: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
		seq_read_cmd |=> rsp_valid && !cmd_ready ##1 !rsp_valid)
		else $error("read answer not in second transfer");

	a_setup_range: assert property (@(posedge core_clk) disable iff (sys_rst) // R15
		seq_setup_cmd |=> mem_we && (mem_addr == {$past(cmd.port), FC_RANGE_W[5:1]}))
		else $error("range not loaded with transfer setup");

	a_task_start: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
		take && (cmd.fc == FC_TASK_W) && !s_r.xfer_act && (s_r.op_pend == CH_RST)
		&& !mclr |-> ##2 xfer_start)
		else $error("task word did not start transfer");

	a_single_xfer: assert property (@(posedge core_clk) disable iff (sys_rst) // R9
		xfer_start |-> !$past(s_r.xfer_act))
		else $error("second transfer started while one active");

	a_nak_retry: assert property (@(posedge core_clk) disable iff (sys_rst) // R11
		irq_req && irq_nak && !irq_ack && !mclr |=> !irq_req [*8] ##1
		(s_r.int_pend[$past(irq_port, 9)]))
		else $error("refused interrupt lost or retried early");

	a_zero_level: assert property (@(posedge core_clk) disable iff (sys_rst) // R13
		irq_req |-> s_r.lvl_nz[irq_port])
		else $error("interrupt raised at zero level");

	a_zero_done: assert property (@(posedge core_clk) disable iff (sys_rst) // R13
		s_r.xfer_act && xfer_done && !s_r.lvl_nz[s_r.act_port]
		|=> !s_r.int_pend[$past(s_r.act_port)] && stat_done[$past(s_r.act_port)])
		else $error("zero level completion posted interrupt");

	a_done_irq: assert property (@(posedge core_clk) disable iff (sys_rst) // R10
		s_r.xfer_act && xfer_done && s_r.lvl_nz[s_r.act_port]
		|=> s_r.int_pend[$past(s_r.act_port)] && stat_done[$past(s_r.act_port)])
		else $error("completion did not post interrupt");

	a_clear_drop: assert property (@(posedge core_clk) disable iff (sys_rst) // R14
		mclr && (attn_in == CH_RST) |=> ((s_r.int_pend & ~s_r.lvl_nz) == CH_RST))
		else $error("master clear kept zero level interrupt");

endmodule

// ===== test/tcc_far_model.sv
// far-side model: processor interrupt answers and tape transfer completion
`timescale 1ns/1ps
module tcc_far_model #(
	parameter int DONE_DLY = 20
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// interrupt cycle
	input  wire logic irq_req,
	input  wire logic refuse,
	output logic      irq_ack,
	output logic      irq_nak,
	// tape side
	input  wire logic xfer_start,
	output logic      xfer_done
);
	int cnt;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_ack   <= 1'b0;
			irq_nak   <= 1'b0;
			xfer_done <= 1'b0;
			cnt       <= 0;
		end else begin
			// one answer per interrupt cycle, refused while asked to
			irq_ack   <= irq_req && !irq_ack && !irq_nak && !refuse;
			irq_nak   <= irq_req && !irq_ack && !irq_nak && refuse;
			xfer_done <= (cnt == 1);
			cnt       <= xfer_start ? DONE_DLY : (cnt > 0 ? cnt - 1 : 0);
		end
	end
endmodule

// ===== test/tcc_cmd_iface_tb.sv
// self-checking bench for the channel command interface
`timescale 1ns/1ps
module tcc_cmd_iface_tb
	import tcc_pkg::*;
;
	localparam logic [6:0] ID  = 7'h2a;
	localparam logic [1:0] ACK = 2'b10;
	localparam logic [1:0] NAK = 2'b01;
	logic        core_clk = 0, sys_rst = 1, mclr = 0, cmd_valid = 0, refuse = 1, busy_x = 0;
	logic [6:0]  ctl_id_sw = ID;
	logic [3:0]  attn_in = 4'h0;
	tcc_cmd_t    cmd = '0;
	logic        cmd_ready, cmd_ack, cmd_nak, rsp_valid, xfer_start, xfer_dir, xfer_done;
	logic        irq_req, irq_ack, irq_nak;
	logic [15:0] rsp_data, d, a;
	logic [15:0] rng[4];
	logic [1:0]  xfer_port, irq_port, p;
	logic [3:0]  stat_done, stat_attn, ch_busy;
	logic [1:0]  q_code[$];
	logic [15:0] q_word[$];
	logic [2:0]  q_xfer[$];
	int          n_mismatch = 0, checked = 0, cyc = 0, seed = 32'h9de0f064;

	tcc_cmd_iface tcc_cmd_iface_inst (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.ctl_id_sw  (ctl_id_sw),
		.mclr       (mclr),
		.cmd_valid  (cmd_valid),
		.cmd        (cmd),
		.cmd_ready  (cmd_ready),
		.cmd_ack    (cmd_ack),
		.cmd_nak    (cmd_nak),
		.rsp_valid  (rsp_valid),
		.rsp_data   (rsp_data),
		.xfer_start (xfer_start),
		.xfer_port  (xfer_port),
		.xfer_dir   (xfer_dir),
		.xfer_done  (xfer_done),
		.attn_in    (attn_in),
		.irq_req    (irq_req),
		.irq_port   (irq_port),
		.irq_ack    (irq_ack),
		.irq_nak    (irq_nak),
		.stat_done  (stat_done),
		.stat_attn  (stat_attn),
		.ch_busy    (ch_busy)
	);

	tcc_far_model tcc_far_model_inst (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.irq_req    (irq_req),
		.refuse     (refuse),
		.irq_ack    (irq_ack),
		.irq_nak    (irq_nak),
		.xfer_start (xfer_start),
		.xfer_done  (xfer_done)
	);

	always #50 core_clk = ~core_clk;

	// ----------------------------------------
	// compare and drive tasks
	// ----------------------------------------
	task automatic chk_code(logic [1:0] got, logic [1:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t code %b expected %b", $time, got, exp);
		end
	endtask

	task automatic chk_word(logic [15:0] got, logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic send(logic [1:0] pt, logic dr, logic [5:0] fc, logic [15:0] dt,
		logic [1:0] ex, logic bad = 0);
		int i;
		@(posedge core_clk);
		#1;
		cmd       = '{bad ? ~ID : ID, pt, dr, fc, dt};
		cmd_valid = 1;
		q_code.push_back(ex);
		for (i = 0; i < 400 && !cmd_ready; i++) @(negedge core_clk);
		@(posedge core_clk);
		#1 cmd_valid = 0;
	endtask

	task automatic rd(logic [1:0] pt, logic [5:0] fc, logic [15:0] ex);
		q_word.push_back(ex);
		send(pt, 1'($random(seed)), fc, 16'($random(seed)), ACK);
	endtask

	task automatic results;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------
	// output watcher
	// ----------------------------------------
	// sampled mid-cycle, where outputs launched by the rising edge have settled
	always @(negedge core_clk) begin
		if (!sys_rst) begin
			if (cmd_valid && cmd_ready) chk_code({cmd_ack, cmd_nak}, q_code.pop_front());
			if (rsp_valid) chk_word(rsp_data, q_word.pop_front());
			if (xfer_start) begin
				chk_code({busy_x, 1'b0}, 2'b00);
				chk_word({13'h0, xfer_dir, xfer_port}, 16'(q_xfer.pop_front()));
				busy_x = 1;
			end else if (xfer_done) begin
				busy_x = 0;
			end
			if (irq_req) chk_code({1'b0, irq_port == 2'd2}, 2'b00);
			cyc++;
			if (cyc > 20000) begin
				n_mismatch++;
				results();
			end
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge core_clk);
		#1 sys_rst = 0;
		p = 2'd0;
		repeat (4) begin
			d = 16'($random(seed));
			a = 16'($random(seed));
			rng[p] = a;
			send(p, 0, FC_RANGE_W, d, ACK);
			rd(p, 6'h0c, d);
			send(p, p[0], FC_ADDR_W, a, ACK);
			rd(p, 6'h08, a);
			rd(p, 6'h0c, a);
			send(p, 0, FC_INTC_W, {15'h0, p != 2'd2}, ACK);
			p++;
		end
		send(3, 0, FC_RANGE_W, 16'h1234, 2'b00, 1);
		rd(3, 6'h0c, rng[3]);
		q_xfer.push_back(3'b000);
		send(0, 1, FC_TASK_W, 16'h0001, ACK);
		q_xfer.push_back(3'b101);
		send(1, 0, FC_TASK_W, 16'h0001, ACK);
		q_xfer.push_back(3'b010);
		send(2, 1, FC_TASK_W, 16'h0001, ACK);
		send(0, 0, FC_RANGE_W, 16'hffff, NAK);
		for (int i = 0; i < 2000 && (q_xfer.size() != 0 || busy_x); i++) @(negedge core_clk);
		chk_code({1'b0, ch_busy[0]}, 2'b01);
		send(0, 0, FC_RANGE_W, 16'hfffe, NAK);
		send(0, 0, FC_CTRL_W, 16'h0000, ACK);
		refuse = 0;
		for (int i = 0; i < 2000 && ch_busy != 4'h0; i++) @(negedge core_clk);
		chk_code({1'b0, ch_busy != 4'h0}, 2'b00);
		rd(0, 6'h0c, rng[0]);
		chk_code({1'b0, stat_done[2]}, 2'b01);
		// attention on a live and on a zero-level port
		@(posedge core_clk);
		#1 attn_in = 4'hc;
		@(posedge core_clk);
		#1 attn_in = 4'h0;
		chk_code({1'b0, ch_busy == 4'h8}, 2'b01);
		for (int i = 0; i < 200 && ch_busy != 4'h0; i++) @(negedge core_clk);
		chk_word({12'h0, stat_attn}, 16'h000c);
		send(3, 0, 6'h19, d, ACK);
		rd(3, FC_STAT1_R, d);
		chk_word({12'h0, stat_attn}, 16'h0004);
		send(2, 0, FC_CTRL_W, 16'h0001, ACK);
		chk_code({1'b0, ch_busy[2]}, 2'b00);
		// master clear drops the queued task, the running one finishes
		q_xfer.push_back(3'b101);
		send(1, 0, FC_TASK_W, 16'h0002, ACK);
		send(2, 0, FC_TASK_W, 16'h0003, ACK);
		mclr = 1;
		@(posedge core_clk);
		#1 mclr = 0;
		for (int i = 0; i < 2000 && (ch_busy != 4'h0 || busy_x); i++) @(negedge core_clk);
		chk_code({stat_done[2], stat_done[1]}, 2'b01);
		chk_code({1'b0, ch_busy != 4'h0}, 2'b00);
		rd(1, 6'h08, rng[1]);
		repeat (4) @(posedge core_clk);
		results();
	end
endmodule
